// file: design/cbt_bit_sync.sv
// CAN bit timing logic: time quanta, edge detection, hard sync and resync
`default_nettype none
`include "cbt_cfg.svh"

// Summary of operation
// - Only recessive-to-dominant transitions can cause any synchronization.
// - Each quantum, sync allowed if previous sample recessive and bus now dominant.
// - Edge in Sync_Seg is synchronous; else error is distance from Sync_Seg end (late) or to Sync_Seg start (early).
// - Hard sync only once at frame start; inside frames only resynchronization.
// - Hard sync restarts the bit as if Sync_Seg just ended.
// - Late edge lengthens Phase_Seg1 by error magnitude, limited to SJW.
// - Early edge shortens Phase_Seg2 by error magnitude, limited to SJW.
// - At most one synchronization between two consecutive sample points.
// - Segment changes last for the current bit only; next bit is nominal.
// - Early edge in Phase_Seg2 shortens it and skips the next Sync_Seg.
// - Bit period runs from sample point to sample point.
// - Sync_Seg is always exactly one time quantum.
// - Programmed timing fields hold value minus one; device adds one.
// - The bit timing state machine advances once per time quantum.
module cbt_bit_sync
  import cbt_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        bus_rx,
  input  wire cbt_timing_t timing,
  input  wire logic        frame_idle,
  output var  cbt_event_t  events
);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus input synchronizer
  logic rx_meta_reg;
  logic rx_sync_reg;

  // Two flops before any logic sees the pin
  // Only the second flop feeds the edge detector and the sampler; the first may be metastable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta_reg <= `CBT_RX_RESET;
      rx_sync_reg <= `CBT_RX_RESET;
    end else begin
      rx_meta_reg <= bus_rx;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Time quantum prescaler
  logic [`CBT_PRESCALE_W-1:0] pre_cnt_reg;
  logic [`CBT_PRESCALE_W-1:0] pre_cnt_next;
  logic                       tq_tick;

  // Quantum ends when the count reaches the programmed value; the compare is >= so a
  // prescaler lowered mid-quantum ends that quantum at once instead of wrapping round
  always_comb begin
    tq_tick = (pre_cnt_reg >= timing.rate_prescaler_field);
    if (tq_tick) begin
      pre_cnt_next = '0;
    end else begin
      pre_cnt_next = pre_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_reg <= '0;
    end else begin
      pre_cnt_reg <= pre_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bit timing state machine
  cbt_state_t           state_reg;
  cbt_state_t           state_next;
  logic [`CBT_CNT_W-1:0] cnt_reg;
  logic [`CBT_CNT_W-1:0] cnt_next;
  logic [`CBT_CNT_W-1:0] ext_reg;
  logic [`CBT_CNT_W-1:0] ext_next;
  logic [`CBT_CNT_W-1:0] short_reg;
  logic [`CBT_CNT_W-1:0] short_next;
  logic                 skip_reg;
  logic                 skip_next;
  logic                 synced_reg;
  logic                 synced_next;
  logic                 hard_used_reg;
  logic                 hard_used_next;
  cbt_event_t           ev_reg;
  cbt_event_t           ev_next;

  logic [`CBT_CNT_W-1:0] seg1_len;
  logic [`CBT_CNT_W-1:0] seg2_len;
  logic [`CBT_CNT_W-1:0] sjw_len;
  logic [`CBT_CNT_W-1:0] err_mag;
  logic                 edge_seen;
  logic                 hard_ok;

  // Next state of the bit timer; all but hard_used_next and the event pulses change only on a quantum tick
  always_comb begin
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    ext_next       = ext_reg;
    short_next     = short_reg;
    skip_next      = skip_reg;
    synced_next    = synced_reg;
    hard_used_next = hard_used_reg && frame_idle; // Rearmed once a frame is under way
    ev_next        = '0;
    err_mag        = '0;
    // Functional lengths are programmed value plus one
    seg1_len = {1'b0, timing.before_sample_length} + 5'h01;
    seg2_len = {2'b00, timing.after_sample_length} + 5'h01;
    sjw_len  = {3'b000, timing.jump_width} + 5'h01;
    // Compare against the last sample point, not the last quantum
    edge_seen = (ev_reg.sample_bit == `CBT_RECESSIVE) &&
                (rx_sync_reg == `CBT_DOMINANT) && !synced_reg;
    // Hard sync needs the processor's permission and stays spent until a frame begins
    hard_ok   = frame_idle && !hard_used_reg;
    if (tq_tick) begin
      ev_next.tq_tick    = 1'b1;
      ev_next.sample_bit = ev_reg.sample_bit;
      cnt_next           = cnt_reg + 5'h01;
      if (edge_seen && hard_ok) begin
        // Treat this quantum as Sync_Seg whatever the phase error
        state_next        = CBT_SEG1;
        cnt_next          = '0;
        ext_next          = '0;
        short_next        = '0;
        skip_next         = 1'b0;
        synced_next       = 1'b1;
        hard_used_next    = 1'b1;
        ev_next.hard_sync = 1'b1;
      end else begin
        case (state_reg)
          CBT_SYNC: begin
            // An edge here is synchronous and needs no correction
            if (edge_seen) begin
              synced_next    = 1'b1;
              ev_next.resync = 1'b1;
            end
            state_next = CBT_SEG1;
            cnt_next   = '0;
          end
          CBT_SEG1: begin
            if (edge_seen) begin
              // Late edge: error counts quanta since the end of Sync_Seg
              err_mag        = cnt_reg + 5'h01;
              ext_next       = (err_mag < sjw_len) ? err_mag : sjw_len;
              synced_next    = 1'b1;
              ev_next.resync = 1'b1;
            end
            if (cnt_reg + 5'h01 >= seg1_len + ext_next) begin
              // Sample point ends one bit period and starts the next
              state_next           = CBT_SEG2;
              cnt_next             = '0;
              ext_next             = '0;
              synced_next          = 1'b0;
              ev_next.sample_point = 1'b1;
              ev_next.sample_bit   = rx_sync_reg;
            end
          end
          default: begin
            if (edge_seen) begin
              // Early edge: error counts quanta left up to Sync_Seg
              err_mag        = seg2_len - cnt_reg;
              short_next     = (err_mag < sjw_len) ? err_mag : sjw_len;
              skip_next      = 1'b1;
              synced_next    = 1'b1;
              ev_next.resync = 1'b1;
            end
            if (cnt_reg + 5'h01 + short_next >= seg2_len) begin
              // Skipping Sync_Seg lets this quantum stand in for it
              state_next = skip_next ? CBT_SEG1 : CBT_SYNC;
              cnt_next   = '0;
              short_next = '0;
              skip_next  = 1'b0;
            end
          end
        endcase
      end
    end else begin
      ev_next.sample_bit = ev_reg.sample_bit;
    end
  end

  // Registers of the bit timer; events other than sample_bit are single-clock pulses
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= CBT_SYNC;
      cnt_reg       <= '0;
      ext_reg       <= '0;
      short_reg     <= '0;
      skip_reg      <= 1'b0;
      synced_reg    <= 1'b0;
      hard_used_reg <= 1'b0;
      ev_reg        <= '{tq_tick: 1'b0, sample_point: 1'b0, sample_bit: `CBT_SAMPLE_RESET,
                         hard_sync: 1'b0, resync: 1'b0};
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      ext_reg       <= ext_next;
      short_reg     <= short_next;
      skip_reg      <= skip_next;
      synced_reg    <= synced_next;
      hard_used_reg <= hard_used_next;
      ev_reg        <= ev_next;
    end
  end

  // Outputs straight from the event register
  // so the one-clock pulses never glitch between quantum ticks
  assign events = ev_reg;

endmodule // cbt_bit_sync

`default_nettype wire

// file: design/cbt_cfg.svh
// Reset values and fixed figures for the CAN bit timing and synchronization logic
`ifndef CBT_CFG_SVH
`define CBT_CFG_SVH

// Bus levels: recessive is high, dominant is low
`define CBT_RECESSIVE     1'b1
`define CBT_DOMINANT      1'b0

// Reset values of the synchronizer and the sampled bit
`define CBT_RX_RESET      1'b1
`define CBT_SAMPLE_RESET  1'b1

// Field widths of the programmed timing values (each holds value minus one) and the width of the internal counters
`define CBT_PRESCALE_W    10
`define CBT_SEG1_W        4
`define CBT_SEG2_W        3
`define CBT_SJW_W         2
`define CBT_CNT_W         5

// Sync_Seg length in time quanta, fixed
`define CBT_SYNC_SEG_TQ   5'h01

`endif

// file: design/cbt_pkg.sv
// Types shared by the CAN bit timing and synchronization logic
`default_nettype none
`include "cbt_cfg.svh"

package cbt_pkg;

  // Programmed bit timing, every field one less than its functional value
  typedef struct packed {
    logic [`CBT_PRESCALE_W-1:0] rate_prescaler_field;
    logic [`CBT_SEG1_W-1:0]     before_sample_length;
    logic [`CBT_SEG2_W-1:0]     after_sample_length;
    logic [`CBT_SJW_W-1:0]      jump_width;
  } cbt_timing_t;

  // Events and sampled value handed to the bit stream processor
  typedef struct packed {
    logic tq_tick;
    logic sample_point;
    logic sample_bit;
    logic hard_sync;
    logic resync;
  } cbt_event_t;

  // Bit time phases, counted from sample point to sample point
  typedef enum logic [1:0] {
    CBT_SYNC,
    CBT_SEG1,
    CBT_SEG2
  } cbt_state_t;

endpackage : cbt_pkg

`default_nettype wire

// file: testbench/cbt_bit_sync_chk.sv
// Assertion checker for the CAN bit timing and synchronization logic
`default_nettype none
module cbt_bit_sync_chk
  import cbt_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        bus_rx,
  input wire cbt_timing_t timing,
  input wire logic        frame_idle,
  input wire cbt_event_t  events
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [9:0]  gap_cnt;
  logic [15:0] bit_cnt;
  logic        tick_seen;
  logic        sp_seen;
  logic        sync_seen;
  logic        any_sync;
  assign any_sync = events.hard_sync | events.resync;
  //////////////////////////////////////////////////////////////////////////
  // Spacing counters; a bit that saw a sync is left out of the length check
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt   <= 10'h000;
      bit_cnt   <= 16'h0000;
      tick_seen <= 1'b0;
      sp_seen   <= 1'b0;
      sync_seen <= 1'b0;
    end else begin
      gap_cnt   <= events.tq_tick ? 10'h000 : gap_cnt + 10'h001;
      bit_cnt   <= events.sample_point ? 16'h0000 : bit_cnt + 16'h0001;
      tick_seen <= tick_seen | events.tq_tick;
      sp_seen   <= sp_seen | events.sample_point;
      sync_seen <= events.sample_point ? 1'b0 : (sync_seen | any_sync);
    end
  end
  //////////////////////////////////////////////////////////////////////////
  tick_gap_a: assert property (
    events.tq_tick && tick_seen |-> gap_cnt == timing.rate_prescaler_field)
    else $error("quantum tick spacing wrong");
  sample_tick_a: assert property (events.sample_point |-> events.tq_tick)
    else $error("sample point off a quantum");
  sync_tick_a: assert property (any_sync |-> events.tq_tick)
    else $error("sync off a quantum");
  single_sync_a: assert property (any_sync |-> !sync_seen)
    else $error("second sync before sample point");
  edge_dir_a: assert property (
    any_sync |-> $past(events.sample_bit) && (!$past(bus_rx, 2) || !$past(bus_rx, 3)))
    else $error("sync without falling edge");
  hard_gate_a: assert property (events.hard_sync |-> $past(frame_idle))
    else $error("hard sync inside a frame");
  bit_len_a: assert property (
    events.sample_point && sp_seen && !sync_seen && !any_sync |-> bit_cnt + 32'h1 ==
    (timing.rate_prescaler_field + 32'h1) * (timing.before_sample_length
    + timing.after_sample_length + 32'h3)) else $error("nominal bit length wrong");
  bit_hold_a: assert property (
    !events.sample_point |-> events.sample_bit == $past(events.sample_bit))
    else $error("sampled bit moved off sample point");
endmodule // cbt_bit_sync_chk
bind cbt_bit_sync cbt_bit_sync_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .bus_rx(bus_rx),
  .timing(timing), .frame_idle(frame_idle), .events(events));
`default_nettype wire

// file: testbench/cbt_bit_sync_tb.sv
// Self-checking testbench for the CAN bit timing and synchronization logic
`default_nettype none
module can_bit_sync_logic_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cbt_pkg::*;
  logic        ref_clk    = 1'b0;
  logic        rst_n      = 1'b0;
  logic        frame_idle = 1'b1;
  logic        start      = 1'b0;
  logic [7:0]  hold       = 8'h00;
  logic        bus_rx;
  cbt_timing_t timing     = '0;
  cbt_event_t  events;
  int          seed = 96, bad_count = 0, checked = 0, cyc = 0, tq_no = 0;
  int          f1, f2, sj, rp, s0, s1, j;
  cbt_bit_sync u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .bus_rx(bus_rx), .timing(timing),
    .frame_idle(frame_idle), .events(events));
  cbt_bus_node u_node (.ref_clk(ref_clk), .start(start), .hold(hold), .bus_rx(bus_rx));
  //////////////////////////////////////////////////////////////////////////
  // Clock, quantum count and hang guard (a run needs under 20000 cycles)
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (events.tq_tick) tq_no <= tq_no + 1;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      test_done();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Waits, bounded, for any event in the mask and returns the quantum count
  task automatic wait_ev(input cbt_event_t mask, output int at);
    int k;
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while ((events & mask) == '0 && k < 2000);
    at = tq_no;
  endtask
  task automatic pulse(input int len);
    hold  = 8'(len);
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
  endtask
  // Quanta from sample to sample for a sync seen j quanta after a sample point
  function automatic int expect_len(input int j);
    int e;
    e = (j <= f2) ? f2 - j + 1 : j - f2 - 1;
    if (e > sj) e = sj;
    if (j <= f2) return (j > f2 - e ? j : f2 - e) + f1;
    return f2 + 1 + f1 + e;
  endfunction
  //////////////////////////////////////////////////////////////////////////
  // First pass is the shortest legal bit, the rest are random settings
  initial begin
    for (int it = 0; it < 8; it++) begin
      rst_n      = 1'b0;
      frame_idle = 1'b1;
      f2 = (it == 0) ? 1 : 1 + $unsigned($random(seed)) % 8;
      f1 = (it == 0) ? 2 : 2 + $unsigned($random(seed)) % 15;
      j  = (f2 < f1 - 1) ? f2 : f1 - 1;
      sj = 1 + $unsigned($random(seed)) % (j < 4 ? j : 4);
      rp = (it == 0) ? 0 : $unsigned($random(seed)) % 4;
      timing = {10'(rp), 4'(f1 - 1), 3'(f2 - 1), 2'(sj - 1)};
      repeat (12) @(negedge ref_clk);
      check(events, 16'h0004);
      rst_n = 1'b1;
      wait_ev(5'h08, s0);
      wait_ev(5'h08, s1);
      check(s1 - s0, f1 + f2 + 1);
      check(events.sample_bit, 1'b1);
      repeat ($unsigned($random(seed)) % 9) @(negedge ref_clk);
      pulse(2 * (f1 + f2 + 1) * (rp + 1));
      wait_ev(5'h02, s0);
      check(events.hard_sync, 1'b1);
      wait_ev(5'h08, s1);
      check(s1 - s0, f1);
      check(events.sample_bit, 1'b0);
      frame_idle = 1'b0;
      repeat (4) begin
        do wait_ev(5'h08, s0); while (events.sample_bit !== 1'b1);
        repeat ($unsigned($random(seed)) % ((f1 + f2 - 1) * (rp + 1))) @(negedge ref_clk);
        pulse(2 * (f1 + f2 + 1) * (rp + 1));
        wait_ev(5'h0b, j);
        // An edge that lands past the sample point is simply skipped
        if (events.resync === 1'b1 || events.hard_sync === 1'b1) begin
          check(events.hard_sync, 1'b0);
          wait_ev(5'h08, s1);
          check(s1 - s0, expect_len(j - s0));
          // At full rate a sample one quantum after the sync lands on the bounce
          check(events.sample_bit, (rp == 0 && s1 - j == 1));
        end
      end
      while (bus_rx !== 1'b1) @(negedge ref_clk);
    end
    test_done();
  end
endmodule // can_bit_sync_logic_tb
`default_nettype wire

// file: testbench/cbt_bus_node.sv
// Far-side node model: a long dominant pulse whose leading edge bounces once
`default_nettype none
module cbt_bus_node (
  input  wire logic       ref_clk,
  input  wire logic       start,
  input  wire logic [7:0] hold,
  output var  logic       bus_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] left_reg = 9'h000;
  // Counts the pulse down; the one-clock gap gives a second falling edge
  always @(posedge ref_clk) begin
    if (start) left_reg <= {1'b0, hold} + 9'h002;
    else if (left_reg != 9'h000) left_reg <= left_reg - 9'h001;
  end
  // A released line is pulled to recessive
  assign bus_rx = (left_reg == 9'h000) || (left_reg == {1'b0, hold} + 9'h001);
endmodule // cbt_bus_node
`default_nettype wire
